// ==== verilog/fault_status_pkg.sv ====
// fault_status_pkg: offsets, field positions and reset values of the
// revision and fault status mirror register group.
// assumes the register interface carries an 8-bit register address.
package fault_status_pkg;

  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 8;
  localparam int FLAG_W = 8;

  // register offsets
  localparam logic [7:0] REVISION_CODE_OFS = 8'h1d;
  localparam logic [7:0] FAULT_STATUS_ONE_OFS = 8'h2a;
  localparam logic [7:0] FAULT_STATUS_TWO_OFS = 8'h2b;
  localparam logic [7:0] FAULT_STATUS_THREE_OFS = 8'h2c;

  // reset values
  localparam logic [7:0] FAULT_STATUS_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // revision fields
  localparam int REV_MAJOR_MSB = 7;
  localparam int REV_MAJOR_LSB = 4;
  localparam int REV_MINOR_MSB = 3;
  localparam int REV_MINOR_LSB = 0;

  // fault_status_one bit positions
  localparam int ONE_OVERVOLT_BIT = 7;
  localparam int ONE_UNDERVOLT_BIT = 6;
  localparam int ONE_OVERCURRENT_TIMEOUT_BIT = 5;
  localparam int ONE_MONITOR_ONE_BIT = 4;
  localparam int ONE_MONITOR_FIVE_BIT = 0;

  // fault_status_two bit positions
  localparam int TWO_SHARE_BIT = 7;
  localparam int TWO_ORING_FET_BIT = 6;
  localparam int TWO_REVERSE_BIT = 5;
  localparam int TWO_SUPPLY_OK_BIT = 4;
  localparam int TWO_GROUND_BIT = 3;
  localparam int TWO_INT_REF_BIT = 2;
  localparam int TWO_EXT_REF_BIT = 1;
  localparam int TWO_SUPPLY_OV_BIT = 0;

  // fault_status_three bit positions
  localparam int THREE_MAINS_OK_BIT = 7;
  localparam int THREE_POWER_ON_REQ_BIT = 6;
  localparam int THREE_POWER_ENABLE_BIT = 5;
  localparam int THREE_POWER_ON_LINK_BIT = 4;
  localparam int THREE_OUTPUT_OK_BIT = 3;
  localparam int THREE_OVERCURRENT_BIT = 2;
  localparam int THREE_PULSE_BIT = 1;
  localparam int THREE_FAULT_LATCH_BIT = 0;

endpackage

// ==== verilog/sticky_flag_bank.sv ====
// sticky_flag_bank: one register's worth of rising-edge sticky flags,
// cleared by a read unless the source is still high.
// assumes flag inputs and the read strobe are synchronous to i_clk_sys.
`timescale 1ns/1ps
`default_nettype none
module sticky_flag_bank
  import fault_status_pkg::*;
#(
  parameter int WIDTH = FLAG_W
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // flag sources and clearing read
  input wire logic [WIDTH-1:0] i_source,
  input wire logic i_read_clear,
  // sticky flags
  output logic [WIDTH-1:0] o_sticky
);

  logic [WIDTH-1:0] source_prev;
  logic [WIDTH-1:0] sticky;
  wire logic [WIDTH-1:0] rise_edge;
  wire logic [WIDTH-1:0] keep_mask;
  wire logic [WIDTH-1:0] next_sticky;

  // level alone never sets a flag, only a low-to-high step does
  assign rise_edge = i_source & ~source_prev;
  // on a read, only flags whose source is still high survive
  assign keep_mask = i_read_clear ? i_source : {WIDTH{1'b1}};
  // a new edge wins over the clearing read in the same cycle
  assign next_sticky = (sticky & keep_mask) | rise_edge;

  // source history starts low so a fault present at reset release
  // registers as a rising edge on the first clock
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      source_prev <= '0;
      sticky <= '0;
    end else begin
      source_prev <= i_source;
      sticky <= next_sticky;
    end
  end

  assign o_sticky = sticky;

endmodule
`default_nettype wire

// ==== verilog/fault_status_mirror_regs.sv ====
// fault_status_mirror_regs: revision register and three read-to-clear
// fault status mirror registers behind the serial-bus register port.
// assumes the bus slave presents a one-cycle read strobe with an address
// and takes the read data one cycle later; fault inputs are synchronous.
// holds the revision code at 1Dh and the status mirrors at 2Ah to 2Ch;
// the fault detectors and the alert routing sit outside this block.
//
// Functional notes
// - revision upper nibble is a read-only device generation code.
// - revision lower nibble is read-only minor revision, counting from zero.
// - sticky flags set only on a rising edge of their source.
// - reading a status register clears flags whose fault has gone.
// - first status register at 2Ah, resets to zero.
// - status one: bit7 overvoltage, bit6 undervoltage, bits4-0 monitors 1-5.
// - status one bit5 timed-out overcurrent; raw overcurrent in status three.
// - status two at 2Bh: share, oring fet, reverse, supply ok, gnd, refs.
// - status three at 2Ch: mains, power-on, enable, link, dc, oc, pulse.
`timescale 1ns/1ps
`default_nettype none
module fault_status_mirror_regs
  import fault_status_pkg::*;
#(
  parameter logic [3:0] MAJOR_REVISION = 4'h0, // arbitrary value
  parameter logic [3:0] MINOR_REVISION = 4'h0 // arbitrary value
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // register port from the serial-bus slave
  input wire logic i_reg_read,
  input wire logic [REG_ADDR_W-1:0] i_reg_addr,
  output logic [REG_DATA_W-1:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // status one sources
  input wire logic i_overvolt_fault,
  input wire logic i_undervolt_fault,
  input wire logic i_overcurrent_timeout,
  input wire logic [4:0] i_monitor_flag,
  // status two sources
  input wire logic i_current_share_fault,
  input wire logic i_oring_fet_fault,
  input wire logic i_reverse_fault,
  input wire logic i_supply_ok_fault,
  input wire logic i_ground_fault,
  input wire logic i_int_ref_fault,
  input wire logic i_ext_ref_fault,
  input wire logic i_supply_ov_fault,
  // status three sources
  input wire logic i_mains_ok_fault,
  input wire logic i_power_on_request_fault,
  input wire logic i_power_enable_fault,
  input wire logic i_power_on_link_fault,
  input wire logic i_output_ok_fault,
  input wire logic i_overcurrent_fault,
  input wire logic i_pulse_fault,
  input wire logic i_fault_latch,
  // live sticky views for alert routing
  output logic [FLAG_W-1:0] o_fault_status_one,
  output logic [FLAG_W-1:0] o_fault_status_two,
  output logic [FLAG_W-1:0] o_fault_status_three
);

  // per-register source words and sticky bank outputs
  wire logic [FLAG_W-1:0] source_one;
  wire logic [FLAG_W-1:0] source_two;
  wire logic [FLAG_W-1:0] source_three;
  wire logic [FLAG_W-1:0] fault_status_one;
  wire logic [FLAG_W-1:0] fault_status_two;
  wire logic [FLAG_W-1:0] fault_status_three;

  // revision, decode and read path
  wire logic [REG_DATA_W-1:0] revision_code;
  wire logic hit_revision;
  wire logic hit_one;
  wire logic hit_two;
  wire logic hit_three;
  wire logic clear_one;
  wire logic clear_two;
  wire logic clear_three;
  logic [REG_DATA_W-1:0] next_rdata;
  logic [REG_DATA_W-1:0] rdata;
  logic rvalid;

  // named sticky flags of status one
  wire logic overvolt_sticky;
  wire logic undervolt_sticky;
  wire logic overcurrent_timeout_sticky;
  wire logic monitor_one_sticky;
  wire logic monitor_two_sticky;
  wire logic monitor_three_sticky;
  wire logic monitor_four_sticky;
  wire logic monitor_five_sticky;
  // named sticky flags of status two
  wire logic current_share_fault_sticky;
  wire logic oring_fet_fault_sticky;
  wire logic reverse_fault_sticky;
  wire logic supply_ok_fault_sticky;
  wire logic ground_fault_sticky;
  wire logic int_ref_fault_sticky;
  wire logic ext_ref_fault_sticky;
  wire logic supply_ov_fault_sticky;
  // named sticky flags of status three
  wire logic mains_ok_fault_sticky;
  wire logic power_on_request_fault_sticky;
  wire logic power_enable_fault_sticky;
  wire logic power_on_link_fault_sticky;
  wire logic output_ok_fault_sticky;
  wire logic overcurrent_fault_sticky;
  wire logic pulse_fault_sticky;
  wire logic fault_latch_sticky;
  // whole words rebuilt from the named flags
  wire logic [FLAG_W-1:0] status_one_word;
  wire logic [FLAG_W-1:0] status_two_word;
  wire logic [FLAG_W-1:0] status_three_word;

  // status one bit map; monitor one lands in bit 4 down to five in bit 0
  assign source_one[ONE_OVERVOLT_BIT] = i_overvolt_fault;
  assign source_one[ONE_UNDERVOLT_BIT] = i_undervolt_fault;
  assign source_one[ONE_OVERCURRENT_TIMEOUT_BIT] =
    i_overcurrent_timeout;
  assign source_one[ONE_MONITOR_ONE_BIT:ONE_MONITOR_FIVE_BIT] = {
    i_monitor_flag[0], i_monitor_flag[1], i_monitor_flag[2],
    i_monitor_flag[3], i_monitor_flag[4]};

  // status two bit map
  assign source_two[TWO_SHARE_BIT] = i_current_share_fault;
  assign source_two[TWO_ORING_FET_BIT] = i_oring_fet_fault;
  assign source_two[TWO_REVERSE_BIT] = i_reverse_fault;
  assign source_two[TWO_SUPPLY_OK_BIT] = i_supply_ok_fault;
  assign source_two[TWO_GROUND_BIT] = i_ground_fault;
  assign source_two[TWO_INT_REF_BIT] = i_int_ref_fault;
  assign source_two[TWO_EXT_REF_BIT] = i_ext_ref_fault;
  assign source_two[TWO_SUPPLY_OV_BIT] = i_supply_ov_fault;

  // status three bit map; raw overcurrent kept apart from the timed one
  assign source_three[THREE_MAINS_OK_BIT] = i_mains_ok_fault;
  assign source_three[THREE_POWER_ON_REQ_BIT] =
    i_power_on_request_fault;
  assign source_three[THREE_POWER_ENABLE_BIT] = i_power_enable_fault;
  assign source_three[THREE_POWER_ON_LINK_BIT] =
    i_power_on_link_fault;
  assign source_three[THREE_OUTPUT_OK_BIT] = i_output_ok_fault;
  assign source_three[THREE_OVERCURRENT_BIT] = i_overcurrent_fault;
  assign source_three[THREE_PULSE_BIT] = i_pulse_fault;
  assign source_three[THREE_FAULT_LATCH_BIT] = i_fault_latch;

  // address decode; unmapped reads return zero and clear nothing
  assign hit_revision = (i_reg_addr == REVISION_CODE_OFS);
  assign hit_one = (i_reg_addr == FAULT_STATUS_ONE_OFS);
  assign hit_two = (i_reg_addr == FAULT_STATUS_TWO_OFS);
  assign hit_three = (i_reg_addr == FAULT_STATUS_THREE_OFS);
  // a clear needs the strobe as well as the address, so an idle bus
  // that happens to show a status address clears nothing
  assign clear_one = i_reg_read & hit_one;
  assign clear_two = i_reg_read & hit_two;
  assign clear_three = i_reg_read & hit_three;

  // revision is wired constant: reading it has no side effect, so a stray
  // factory-test read by the host is harmless
  assign revision_code[REV_MAJOR_MSB:REV_MAJOR_LSB] = MAJOR_REVISION;
  assign revision_code[REV_MINOR_MSB:REV_MINOR_LSB] = MINOR_REVISION;

  // one sticky bank per status register, reset to all zeros
  sticky_flag_bank #(
    .WIDTH(FLAG_W)
  ) u_status_one (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_source(source_one),
    .i_read_clear(clear_one),
    .o_sticky(fault_status_one)
  );

  // status two bank; its edges and clears are independent of the others
  sticky_flag_bank #(
    .WIDTH(FLAG_W)
  ) u_status_two (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_source(source_two),
    .i_read_clear(clear_two),
    .o_sticky(fault_status_two)
  );

  sticky_flag_bank #(
    .WIDTH(FLAG_W)
  ) u_status_three (
    .i_clk_sys(i_clk_sys),
    .i_nrst(i_nrst),
    .i_source(source_three),
    .i_read_clear(clear_three),
    .o_sticky(fault_status_three)
  );

  // named flags pulled out of the sticky banks, status one
  assign overvolt_sticky =
    fault_status_one[ONE_OVERVOLT_BIT];
  assign undervolt_sticky =
    fault_status_one[ONE_UNDERVOLT_BIT];
  assign overcurrent_timeout_sticky =
    fault_status_one[ONE_OVERCURRENT_TIMEOUT_BIT];
  assign monitor_one_sticky =
    fault_status_one[ONE_MONITOR_ONE_BIT];
  assign monitor_two_sticky =
    fault_status_one[ONE_MONITOR_ONE_BIT-1];
  assign monitor_three_sticky =
    fault_status_one[ONE_MONITOR_ONE_BIT-2];
  assign monitor_four_sticky =
    fault_status_one[ONE_MONITOR_ONE_BIT-3];
  assign monitor_five_sticky =
    fault_status_one[ONE_MONITOR_FIVE_BIT];

  // status two
  assign current_share_fault_sticky =
    fault_status_two[TWO_SHARE_BIT];
  assign oring_fet_fault_sticky =
    fault_status_two[TWO_ORING_FET_BIT];
  assign reverse_fault_sticky =
    fault_status_two[TWO_REVERSE_BIT];
  assign supply_ok_fault_sticky =
    fault_status_two[TWO_SUPPLY_OK_BIT];
  assign ground_fault_sticky =
    fault_status_two[TWO_GROUND_BIT];
  assign int_ref_fault_sticky =
    fault_status_two[TWO_INT_REF_BIT];
  assign ext_ref_fault_sticky =
    fault_status_two[TWO_EXT_REF_BIT];
  assign supply_ov_fault_sticky =
    fault_status_two[TWO_SUPPLY_OV_BIT];

  // status three
  assign mains_ok_fault_sticky =
    fault_status_three[THREE_MAINS_OK_BIT];
  assign power_on_request_fault_sticky =
    fault_status_three[THREE_POWER_ON_REQ_BIT];
  assign power_enable_fault_sticky =
    fault_status_three[THREE_POWER_ENABLE_BIT];
  assign power_on_link_fault_sticky =
    fault_status_three[THREE_POWER_ON_LINK_BIT];
  assign output_ok_fault_sticky =
    fault_status_three[THREE_OUTPUT_OK_BIT];
  assign overcurrent_fault_sticky =
    fault_status_three[THREE_OVERCURRENT_BIT];
  assign pulse_fault_sticky =
    fault_status_three[THREE_PULSE_BIT];
  assign fault_latch_sticky =
    fault_status_three[THREE_FAULT_LATCH_BIT];

  // the read mux and the live outputs share these words, so the host
  // and the alert routing can never see two different bit maps
  assign status_one_word = {overvolt_sticky, undervolt_sticky,
    overcurrent_timeout_sticky, monitor_one_sticky, monitor_two_sticky,
    monitor_three_sticky, monitor_four_sticky, monitor_five_sticky};
  assign status_two_word = {current_share_fault_sticky,
    oring_fet_fault_sticky, reverse_fault_sticky, supply_ok_fault_sticky,
    ground_fault_sticky, int_ref_fault_sticky, ext_ref_fault_sticky,
    supply_ov_fault_sticky};
  assign status_three_word = {mains_ok_fault_sticky,
    power_on_request_fault_sticky, power_enable_fault_sticky,
    power_on_link_fault_sticky, output_ok_fault_sticky,
    overcurrent_fault_sticky, pulse_fault_sticky, fault_latch_sticky};

  // read mux; data returned is the value before the read's clear applies,
  // so the host always sees the flags that the read is clearing
  // the mux follows the address alone; only the strobe captures it
  always_comb begin
    if (hit_revision) begin
      next_rdata = revision_code;
    end else if (hit_one) begin
      next_rdata = status_one_word;
    end else if (hit_two) begin
      next_rdata = status_two_word;
    end else if (hit_three) begin
      next_rdata = status_three_word;
    end else begin
      next_rdata = UNMAPPED_READ_VALUE;
    end
  end

  // read data register, held until the next read; rvalid is a one-cycle
  // pulse, so a slave that needs more time must latch rvalid, not rdata
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata <= '0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= i_reg_read;
      if (i_reg_read) begin
        rdata <= next_rdata;
      end
    end
  end

  assign o_reg_rdata = rdata;
  assign o_reg_rvalid = rvalid;
  assign o_fault_status_one = status_one_word;
  assign o_fault_status_two = status_two_word;
  assign o_fault_status_three = status_three_word;

endmodule
`default_nettype wire

// ==== verification/host_model.sv ====
// host_model: serial-bus host side, turns a request pulse into a read strobe.
// assumes requests come from the bench, one at a time, after reset release.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // request from the bench
  input wire logic i_go,
  input wire logic [7:0] i_addr,
  // register port towards the block
  output logic o_read,
  output logic [7:0] o_addr
);
  // revision reads only come from factory-test scenarios
  // idle address shows the inverse of the last request and holds it, so
  // a stale copy of a status address never sits on the bus between reads
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_read <= 1'b0;
      o_addr <= 8'h00;
    end else begin
      o_read <= i_go;
      o_addr <= i_go ? i_addr : ~i_addr;
    end
  end
endmodule
`default_nettype wire

// ==== verification/fault_status_assertions.sv ====
// fault_status_checker: port-level properties of the status register group.
// assumes it is bound to fault_status_mirror_regs.
`timescale 1ns/1ps
`default_nettype none
module fault_status_checker #(
  parameter logic [3:0] MAJOR_REVISION = 4'h0,
  parameter logic [3:0] MINOR_REVISION = 4'h0
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_nrst,
  // register port
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_addr,
  input wire logic [7:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // watched fault sources
  input wire logic [4:0] i_monitor_flag,
  input wire logic i_overvolt_fault,
  input wire logic i_overcurrent_fault,
  input wire logic i_fault_latch,
  input wire logic i_supply_ov_fault,
  // live sticky views
  input wire logic [7:0] o_fault_status_one,
  input wire logic [7:0] o_fault_status_two,
  input wire logic [7:0] o_fault_status_three
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  // reads of status one, the cause of two checks below
  sequence s_take_one;
    i_reg_read && i_reg_addr == 8'h2a;
  endsequence
  a_rvalid_follows: assert property (i_reg_read |=> o_reg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (o_reg_rvalid |-> $past(i_reg_read))
    else $error("answer without a read");
  a_rev_value: assert property (i_reg_read && i_reg_addr == 8'h1d |=>
    o_reg_rdata == {MAJOR_REVISION, MINOR_REVISION})
    else $error("revision value wrong");
  a_one_readback: assert property (s_take_one |=>
    o_reg_rdata == $past(o_fault_status_one))
    else $error("status one read data wrong");
  a_clear_on_read: assert property (s_take_one ##0 !i_overvolt_fault
    |=> !o_fault_status_one[7])
    else $error("flag not cleared by read");
  a_flag_held: assert property (i_supply_ov_fault && o_fault_status_two[0]
    |=> o_fault_status_two[0])
    else $error("flag lost while fault present");
  a_edge_wins: assert property (i_reg_read && i_reg_addr == 8'h2b
    && $rose(i_supply_ov_fault) |=> o_fault_status_two[0])
    else $error("edge lost to clearing read");
  a_oc_edge_only: assert property ($rose(o_fault_status_three[2]) |->
    $past(i_overcurrent_fault) && !$past(i_overcurrent_fault, 2))
    else $error("overcurrent flag set without rising edge");
  a_ov_edge_sets: assert property ($rose(i_overvolt_fault) |=>
    o_fault_status_one[7])
    else $error("overvoltage flag not set");
  a_monitor_map: assert property ($rose(i_monitor_flag[0]) |=>
    o_fault_status_one[4])
    else $error("monitor one flag not in bit 4");
  a_latch_bit: assert property ($rose(i_fault_latch) |=>
    o_fault_status_three[0])
    else $error("fault latch flag not in bit 0");
endmodule
bind fault_status_mirror_regs fault_status_checker #(
  .MAJOR_REVISION(MAJOR_REVISION), .MINOR_REVISION(MINOR_REVISION)
) checker_inst (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
  .i_reg_read(i_reg_read), .o_reg_rvalid(o_reg_rvalid),
  .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
  .i_monitor_flag(i_monitor_flag),
  .i_overvolt_fault(i_overvolt_fault),
  .i_overcurrent_fault(i_overcurrent_fault),
  .i_fault_latch(i_fault_latch), .i_supply_ov_fault(i_supply_ov_fault),
  .o_fault_status_one(o_fault_status_one),
  .o_fault_status_two(o_fault_status_two),
  .o_fault_status_three(o_fault_status_three));
`default_nettype wire

// ==== verification/tb.sv ====
// tb: reads the status group through host_model and checks flag behaviour.
// assumes host_model adds one cycle between request and read strobe.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import fault_status_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, go = 1'b0;
  logic [7:0] ga = 8'h00, m;
  logic [7:0] src [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] ofs [3] = '{8'h2a, 8'h2b, 8'h2c};
  wire logic rd_s, rv;
  wire logic [7:0] ra, rdata;
  wire logic [7:0] live [3];
  int bad_count = 0, compares = 0;
  always #2.5 clk = ~clk;
  host_model host_model_inst (.i_clk_sys(clk), .i_nrst(nrst), .i_go(go),
    .i_addr(ga), .o_read(rd_s), .o_addr(ra));
  // revision values are arbitrary
  fault_status_mirror_regs #(.MAJOR_REVISION(4'h3), .MINOR_REVISION(4'h2))
  fault_status_mirror_regs_inst (.i_clk_sys(clk), .i_nrst(nrst),
    .i_reg_read(rd_s), .i_reg_addr(ra), .o_reg_rdata(rdata),
    .o_reg_rvalid(rv), .i_overvolt_fault(src[0][7]),
    .i_undervolt_fault(src[0][6]), .i_overcurrent_timeout(src[0][5]),
    .i_monitor_flag({src[0][0], src[0][1], src[0][2], src[0][3], src[0][4]}),
    .i_current_share_fault(src[1][7]), .i_oring_fet_fault(src[1][6]),
    .i_reverse_fault(src[1][5]), .i_supply_ok_fault(src[1][4]),
    .i_ground_fault(src[1][3]), .i_int_ref_fault(src[1][2]),
    .i_ext_ref_fault(src[1][1]), .i_supply_ov_fault(src[1][0]),
    .i_mains_ok_fault(src[2][7]), .i_power_on_request_fault(src[2][6]),
    .i_power_enable_fault(src[2][5]), .i_power_on_link_fault(src[2][4]),
    .i_output_ok_fault(src[2][3]), .i_overcurrent_fault(src[2][2]),
    .i_pulse_fault(src[2][1]), .i_fault_latch(src[2][0]),
    .o_fault_status_one(live[0]), .o_fault_status_two(live[1]),
    .o_fault_status_three(live[2]));
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  // one read through the host; answer wait is bounded
  task automatic rd(logic [7:0] a, logic [7:0] e);
    int i;
    @(posedge clk);
    go <= 1'b1;
    ga <= a;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      #1;
      if (rv === 1'b1) break;
    end
    if (i == 8) begin
      chk("rvalid", 8'h01, 8'h00);
      give_verdict();
    end else begin
      chk("rdata", e, rdata);
    end
  endtask
  task automatic put(int r, logic [7:0] v);
    @(posedge clk);
    src[r] <= v;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    foreach (ofs[r]) rd(ofs[r], 8'h00);
    rd(8'h1d, 8'h32);
    rd(8'h40, 8'h00);
    $display("test reset and revision done");
    // a short pulse on each source must leave exactly its own bit
    for (int r = 0; r < 3; r++) begin
      for (int b = 0; b < 8; b++) begin
        m = 8'h01 << b;
        put(r, m);
        put(r, 8'h00);
        #1;
        chk("live", m, live[r]);
        rd(ofs[r], m);
        rd(ofs[r], 8'h00);
      end
    end
    $display("test bit map done");
    // a held fault survives reads until it goes away, status one and two
    for (int r = 0; r < 2; r++) begin
      m = (r == 0) ? 8'h80 : 8'h01;
      put(r, m);
      rd(ofs[r], m);
      rd(ofs[r], m);
      put(r, 8'h00);
      rd(ofs[r], m);
      rd(ofs[r], 8'h00);
    end
    $display("test persisting fault done");
    // source rises exactly at the clearing read's edge, then falls
    @(posedge clk);
    go <= 1'b1;
    ga <= ofs[1];
    @(posedge clk);
    go <= 1'b0;
    src[1] <= 8'h01;
    @(posedge clk);
    src[1] <= 8'h00;
    repeat (2) @(posedge clk);
    rd(ofs[1], 8'h01);
    rd(ofs[1], 8'h00);
    $display("test edge during read done");
    give_verdict();
  end
endmodule
`default_nettype wire
